// ===== fuc_pkg.sv
// Shared constants, types and helpers of the counter compare outputs
package fuc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_PRESET = 5'h04;
  localparam logic [4:0] OFS_FLAGS = 5'h08;
  localparam logic [4:0] OFS_COUNT = 5'h0C;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h10;
  localparam logic [4:0] OFS_IRQ_CLEAR = 5'h14;
  localparam logic [4:0] OFS_IRQ_ENABLE = 5'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_OUT1_STATE = 0;
  localparam int CTRL_OUT1_MODE = 1;
  localparam int CTRL_OUT2_STATE = 2;
  localparam int CTRL_OUT2_MODE = 3;
  localparam int FLAG_GT = 0;
  localparam int FLAG_EQ = 1;
  localparam int FLAG_LT = 2;
  localparam int FLAG_CARRY = 3;
  localparam int IRQ_CARRY = 0;
  localparam int IRQ_EQ = 1;

  // ----------------------------------------------------------------
  // Values after reset and BCD constants
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [15:0] PRESET_RESET = 16'h0000;
  localparam logic [1:0] IRQ_EN_RESET = 2'h0;
  localparam logic [15:0] BCD_0000 = 16'h0000;
  localparam logic [15:0] BCD_0001 = 16'h0001;
  localparam logic [15:0] BCD_9998 = 16'h9998;
  localparam logic [15:0] BCD_9999 = 16'h9999;

  // ----------------------------------------------------------------
  // Count event history, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    EV_NONE = 4'b0001,
    EV_INC = 4'b0010,
    EV_DEC = 4'b0100,
    EV_RST = 4'b1000
  } fuc_evt_e;

  // Valid BCD orders the same way as plain binary
  function automatic logic fuc_bcd_ge(input logic [15:0] a,
                                      input logic [15:0] b);
    fuc_bcd_ge = (a >= b);
  endfunction

  function automatic logic fuc_bcd_le(input logic [15:0] a,
                                      input logic [15:0] b);
    fuc_bcd_le = (a <= b);
  endfunction

endpackage

// ===== fuc_output_channel.sv
// One discrete output: manual or counter mode with direction capture
`timescale 1ns/1ns
module fuc_output_channel (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic load_i,
  input wire logic [15:0] preset_i,
  input wire logic [15:0] count_i,
  input wire logic mode_i,
  input wire logic state_i,
  output logic out_o
);

  typedef struct packed {
    logic up;
    logic out;
  } fuc_chan_s;

  fuc_chan_s q;
  fuc_chan_s d;
  logic cmp;

  always_comb
  begin
    d = q;
    if (load_i)
    begin
      d.up = fuc_pkg::fuc_bcd_ge(preset_i, count_i);
    end
    if (d.up)
    begin
      cmp = fuc_pkg::fuc_bcd_ge(count_i, preset_i);
    end
    else
    begin
      cmp = fuc_pkg::fuc_bcd_le(count_i, preset_i);
    end
    if (mode_i)
    begin
      d.out = cmp ^ state_i;
    end
    else
    begin
      d.out = state_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      q <= '{up: 1'b1, out: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  assign out_o = q.out;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_MANUAL_FOLLOWS: assert property (@(posedge clk_i)
    disable iff (!reset_n_i) !mode_i |=> out_o == $past(state_i))
    else $error("manual output does not follow state");

  AST_UP_REACHED: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    q.up && !load_i && mode_i && !state_i && count_i >= preset_i
    |=> out_o)
    else $error("upward compare not true at or above preset");

  AST_DOWN_REACHED: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    !q.up && !load_i && mode_i && !state_i && count_i > preset_i
    |=> !out_o)
    else $error("downward compare true above preset");

  AST_INVERTED: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    q.up && !load_i && mode_i && state_i && count_i < preset_i
    |=> out_o)
    else $error("inverted counter output wrong below preset");

  AST_EQUAL_LOAD_UP: assert property (@(posedge clk_i)
    disable iff (!reset_n_i) load_i && preset_i == count_i |=> q.up)
    else $error("equal at load not taken as upward");

  AST_DIR_HELD: assert property (@(posedge clk_i)
    disable iff (!reset_n_i) !load_i |=> $stable(q.up))
    else $error("direction changed without a preset load");

endmodule

// ===== fuc_carry_detect.sv
// Carry/borrow sequence detector on the count event history
`timescale 1ns/1ns
module fuc_carry_detect (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic inc_i,
  input wire logic dec_i,
  input wire logic ext_rst_i,
  input wire logic [15:0] count_i,
  output logic carry_o
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] prev;
    fuc_pkg::fuc_evt_e evt1;
    fuc_pkg::fuc_evt_e evt2;
    logic pulse;
  } fuc_carry_s;

  fuc_carry_s q;
  fuc_carry_s d;
  fuc_pkg::fuc_evt_e now;
  logic hit;

  always_comb
  begin
    d = q;
    d.cnt = count_i;
    d.pulse = 1'b0;
    hit = 1'b0;
    if (ext_rst_i)
    begin
      now = fuc_pkg::EV_RST;
    end
    else if (inc_i)
    begin
      now = fuc_pkg::EV_INC;
    end
    else if (dec_i)
    begin
      now = fuc_pkg::EV_DEC;
    end
    else
    begin
      now = fuc_pkg::EV_NONE;
    end
    case (now)
      fuc_pkg::EV_INC, fuc_pkg::EV_DEC:
      begin
        if (q.cnt == fuc_pkg::BCD_0000 && q.evt1 != fuc_pkg::EV_RST)
        begin
          hit = (q.prev == fuc_pkg::BCD_0001 &&
                 count_i == fuc_pkg::BCD_9999) ||
                (q.prev == fuc_pkg::BCD_9999 &&
                 count_i == fuc_pkg::BCD_0001) ||
                (q.prev == fuc_pkg::BCD_0001 &&
                 count_i == fuc_pkg::BCD_0001);
        end
        if (q.prev == fuc_pkg::BCD_9998 && q.cnt == fuc_pkg::BCD_9999 &&
            count_i == fuc_pkg::BCD_9998)
        begin
          hit = 1'b1;
        end
        if (q.evt1 == fuc_pkg::EV_RST)
        begin
          hit = (q.evt2 == fuc_pkg::EV_INC && now == fuc_pkg::EV_DEC) ||
                (q.evt2 == fuc_pkg::EV_DEC);
        end
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
    if (now != fuc_pkg::EV_NONE)
    begin
      d.prev = q.cnt;
      d.evt1 = now;
      d.evt2 = q.evt1;
      d.pulse = hit;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      q <= '{cnt: 16'h0000, prev: 16'h0000, evt1: fuc_pkg::EV_NONE,
             evt2: fuc_pkg::EV_NONE, pulse: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  assign carry_o = q.pulse;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ROLL_DOWN: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    dec_i && !inc_i && !ext_rst_i && q.evt1 == fuc_pkg::EV_DEC &&
    q.prev == 16'h0001 && q.cnt == 16'h0000 && count_i == 16'h9999
    |=> carry_o)
    else $error("decrement rollover missed");

  AST_REVERSE_TOP: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    dec_i && !ext_rst_i && !inc_i && q.prev == 16'h9998 &&
    q.cnt == 16'h9999 && count_i == 16'h9998 |=> carry_o)
    else $error("reversal at top boundary missed");

  AST_RESET_SEQ: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    (inc_i || dec_i) && !ext_rst_i && q.evt1 == fuc_pkg::EV_RST &&
    q.evt2 == fuc_pkg::EV_DEC |=> carry_o)
    else $error("decrement-reset-count sequence missed");

endmodule

// ===== fuc_compare_outputs.sv
// Compare flags, carry/borrow latch and two outputs behind Avalon-MM
// ----------------------------------------------------------------
// What this block does
// - Two discrete outputs, each driven by software or by the compare.
// - Greater, equal and less flags of count against preset are reported.
// - Carry/borrow flags a rollover 0001-0000-9999 or 9999-0000-0001.
// - Carry/borrow flags a turn at 0001-0000-0001 or 9998-9999-9998.
// - Carry/borrow flags inc-reset-dec and dec-reset-any-count sequences.
// - Flags are handed to the processor once per scan read.
// - A mode bit per output selects manual (0) or counter (1) mode.
// - In manual mode the output copies its state bit.
// - A new preset is compared once to the count to fix the direction.
// - Preset first above count: compare true while count is at or above it.
// - Preset first below count: compare true while count is at or below it.
// - In counter mode the output is the compare, inverted by state bit 1.
// - The counter-mode output tracks the compare without waiting for a scan.
// - State and mode bits of both outputs sit in the control register.
// - Count and preset are four-digit BCD values 0000 to 9999.
// ----------------------------------------------------------------
//
// Chosen here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module fuc_compare_outputs (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [15:0] count_i,
  input wire logic inc_i,
  input wire logic dec_i,
  input wire logic ext_rst_i,
  output logic out1_o,
  output logic out2_o,
  output logic irq_o
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [3:0] ctrl;
    logic [15:0] preset;
    logic load;
    logic carry;
    logic eq_prev;
    logic [1:0] irq_st;
    logic [1:0] irq_en;
  } fuc_top_s;

  fuc_top_s q;
  fuc_top_s d;
  logic req;
  logic wr_ok;
  logic rd_ok;
  logic gt;
  logic eq;
  logic lt;
  logic carry_evt;
  logic [1:0] irq_evt;
  logic [1:0] irq_clr;
  logic [3:0] flags;
  logic [1:0] chan_out;

  // Flag register decode, shared by the carry clear and its checks
  function automatic logic at_flags(input logic [4:0] a);
    at_flags = (a == fuc_pkg::OFS_FLAGS);
  endfunction

  // ----------------------------------------------------------------
  // Live comparison
  // ----------------------------------------------------------------
  always_comb
  begin
    eq = (count_i == q.preset);
    gt = !fuc_pkg::fuc_bcd_le(count_i, q.preset);
    lt = !fuc_pkg::fuc_bcd_ge(count_i, q.preset);
    flags = 4'h0;
    flags[fuc_pkg::FLAG_GT] = gt;
    flags[fuc_pkg::FLAG_EQ] = eq;
    flags[fuc_pkg::FLAG_LT] = lt;
    flags[fuc_pkg::FLAG_CARRY] = q.carry;
  end

  // ----------------------------------------------------------------
  // Bus slave and registers
  // ----------------------------------------------------------------
  // One wait cycle: data is fetched on the first edge, given on the next
  assign req = avs_read_i || avs_write_i;
  assign wr_ok = avs_write_i && q.ack;
  assign rd_ok = avs_read_i && q.ack;

  always_comb
  begin
    d = q;
    d.ack = req && !q.ack;
    d.load = 1'b0;
    irq_clr = 2'h0;
    if (req && !q.ack)
    begin
      d.rdata = 32'h0000_0000;
      case (avs_address_i)
        fuc_pkg::OFS_CTRL: d.rdata[3:0] = q.ctrl;
        fuc_pkg::OFS_PRESET: d.rdata[15:0] = q.preset;
        fuc_pkg::OFS_FLAGS: d.rdata[3:0] = flags;
        fuc_pkg::OFS_COUNT: d.rdata[15:0] = count_i;
        fuc_pkg::OFS_IRQ_STATUS: d.rdata[1:0] = q.irq_st;
        fuc_pkg::OFS_IRQ_ENABLE: d.rdata[1:0] = q.irq_en;
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_ok)
    begin
      case (avs_address_i)
        fuc_pkg::OFS_CTRL:
        begin
          if (avs_byteenable_i[0])
          begin
            d.ctrl = avs_writedata_i[3:0];
          end
        end
        fuc_pkg::OFS_PRESET:
        begin
          if (avs_byteenable_i[0])
          begin
            d.preset[7:0] = avs_writedata_i[7:0];
          end
          if (avs_byteenable_i[1])
          begin
            d.preset[15:8] = avs_writedata_i[15:8];
          end
          d.load = |avs_byteenable_i[1:0];
        end
        fuc_pkg::OFS_IRQ_CLEAR:
        begin
          if (avs_byteenable_i[0])
          begin
            irq_clr = avs_writedata_i[1:0];
          end
        end
        fuc_pkg::OFS_IRQ_ENABLE:
        begin
          if (avs_byteenable_i[0])
          begin
            d.irq_en = avs_writedata_i[1:0];
          end
        end
        default:
        begin
          d.load = 1'b0;
        end
      endcase
    end
    // Only a carry that was actually returned is cleared; set wins
    if (rd_ok && at_flags(avs_address_i) &&
        q.rdata[fuc_pkg::FLAG_CARRY])
    begin
      d.carry = 1'b0;
    end
    if (carry_evt)
    begin
      d.carry = 1'b1;
    end
    d.eq_prev = eq;
    irq_evt = 2'h0;
    irq_evt[fuc_pkg::IRQ_CARRY] = carry_evt;
    irq_evt[fuc_pkg::IRQ_EQ] = eq && !q.eq_prev;
    d.irq_st = (q.irq_st & ~irq_clr) | irq_evt;
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      // Equal counts as already seen, so reset raises no equal event
      q <= '{ack: 1'b0, rdata: 32'h0000_0000,
             ctrl: fuc_pkg::CTRL_RESET, preset: fuc_pkg::PRESET_RESET,
             load: 1'b0, carry: 1'b0, eq_prev: 1'b1, irq_st: 2'h0,
             irq_en: fuc_pkg::IRQ_EN_RESET};
    end
    else
    begin
      q <= d;
    end
  end

  assign avs_waitrequest_o = req && !q.ack;
  assign avs_readdata_o = q.rdata;
  assign irq_o = |(q.irq_st & q.irq_en);

  // ----------------------------------------------------------------
  // Carry/borrow detection and output channels
  // ----------------------------------------------------------------
  fuc_carry_detect u_carry (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .inc_i(inc_i),
    .dec_i(dec_i),
    .ext_rst_i(ext_rst_i),
    .count_i(count_i),
    .carry_o(carry_evt)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_chan
      fuc_output_channel u_chan (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .load_i(q.load),
        .preset_i(q.preset),
        .count_i(count_i),
        .mode_i(q.ctrl[2 * gi + 1]),
        .state_i(q.ctrl[2 * gi]),
        .out_o(chan_out[gi])
      );
    end
  endgenerate

  assign out1_o = chan_out[0];
  assign out2_o = chan_out[1];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ONE_WAIT: assert property (@(posedge clk_i)
    disable iff (!reset_n_i) req && !q.ack |=> !avs_waitrequest_o)
    else $error("bus answer not given after one wait cycle");

  AST_ONE_FLAG: assert property (@(posedge clk_i)
    disable iff (!reset_n_i) $onehot({gt, eq, lt}))
    else $error("compare flags not exactly one");

  AST_CARRY_HELD: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    q.carry && !(rd_ok && avs_address_i == fuc_pkg::OFS_FLAGS)
    |=> q.carry)
    else $error("carry dropped before it was read");

  AST_CARRY_SET: assert property (@(posedge clk_i)
    disable iff (!reset_n_i) carry_evt |=> q.carry)
    else $error("carry event lost");

  AST_MANUAL_PATH: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    wr_ok && avs_address_i == fuc_pkg::OFS_CTRL && avs_byteenable_i[0]
    && avs_writedata_i[3:0] == 4'h1 |=> ##1 out1_o && !out2_o)
    else $error("control write not reflected on outputs");

  AST_PRESET_LOAD: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    wr_ok && avs_address_i == fuc_pkg::OFS_PRESET &&
    |avs_byteenable_i[1:0] |=> q.load)
    else $error("preset write did not start a direction capture");

  AST_LOAD_ONCE: assert property (@(posedge clk_i)
    disable iff (!reset_n_i) q.load |=> !q.load)
    else $error("direction capture repeated without a new preset");

  AST_CTRL_WRITE: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    wr_ok && avs_address_i == fuc_pkg::OFS_CTRL && avs_byteenable_i[0]
    |=> q.ctrl == $past(avs_writedata_i[3:0]))
    else $error("control write not stored");

  AST_CARRY_CLEAR: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    rd_ok && at_flags(avs_address_i) && q.rdata[fuc_pkg::FLAG_CARRY] &&
    !carry_evt |=> !q.carry)
    else $error("carry not cleared after it was read");

  AST_FLAGS_FETCH: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    req && !q.ack && at_flags(avs_address_i)
    |=> avs_readdata_o[3:0] == $past(flags))
    else $error("flag word not captured at the fetch edge");

  AST_EQ_EVENT: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    eq && !q.eq_prev |=> q.irq_st[fuc_pkg::IRQ_EQ])
    else $error("equal event not recorded");

  AST_CARRY_EVENT: assert property (@(posedge clk_i)
    disable iff (!reset_n_i) carry_evt |=> q.irq_st[fuc_pkg::IRQ_CARRY])
    else $error("carry event not recorded in status");

  AST_STATUS_CLEAR: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    wr_ok && avs_address_i == fuc_pkg::OFS_IRQ_CLEAR && avs_byteenable_i[0]
    && avs_writedata_i[fuc_pkg::IRQ_CARRY] && !carry_evt
    |=> !q.irq_st[fuc_pkg::IRQ_CARRY])
    else $error("carry status not cleared by its clear bit");

  AST_OUT1_MANUAL: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    !q.ctrl[fuc_pkg::CTRL_OUT1_MODE]
    |=> out1_o == $past(q.ctrl[fuc_pkg::CTRL_OUT1_STATE]))
    else $error("output 1 not driven by software in manual mode");

  AST_OUT2_MANUAL: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    !q.ctrl[fuc_pkg::CTRL_OUT2_MODE]
    |=> out2_o == $past(q.ctrl[fuc_pkg::CTRL_OUT2_STATE]))
    else $error("output 2 not driven by software in manual mode");

  AST_IDLE_ACK: assert property (@(posedge clk_i)
    disable iff (!reset_n_i) !req |=> !q.ack)
    else $error("bus answer given without a request");

endmodule

// ===== fuc_proc_model.sv
// Processor model: scans flags and writes controls over the register bus
`timescale 1ns/1ns
module fuc_proc_model (
  input wire logic clk_i,
  input wire logic avs_waitrequest_i,
  input wire logic [31:0] avs_readdata_i,
  output logic [4:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0] avs_byteenable_o
);
  initial
  begin
    avs_address_o = 5'h1F;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = 32'hA5A5A5A5;
    avs_byteenable_o = 4'h0;
  end

  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Released lines show scrambled values so stale data never matches
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_o <= a;
    avs_writedata_o <= d;
    avs_byteenable_o <= 4'hF;
    avs_write_o <= 1'b1;
    do @(posedge clk_i); while (avs_waitrequest_i !== 1'b0);
    avs_write_o <= 1'b0;
    avs_address_o <= ~a;
    avs_writedata_o <= ~d;
    avs_byteenable_o <= 4'h0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk_i);
    avs_address_o <= a;
    avs_byteenable_o <= 4'hF;
    avs_read_o <= 1'b1;
    do @(posedge clk_i); while (avs_waitrequest_i !== 1'b0);
    d = avs_readdata_i;
    avs_read_o <= 1'b0;
    avs_address_o <= ~a;
    avs_byteenable_o <= 4'h0;
  endtask

  // ----------------------------------------------------------------
  // User logic views
  // ----------------------------------------------------------------
  // One flag transfer per scan; a read is one scan
  task automatic scan(output logic [31:0] d);
    rd(fuc_pkg::OFS_FLAGS, d);
  endtask

  task automatic set_ctrl(input logic s1, input logic m1,
                          input logic s2, input logic m2);
    wr(fuc_pkg::OFS_CTRL, {28'h0000000, m2, s2, m1, s1});
  endtask
endmodule

// ===== fuc_compare_outputs_tb.sv
// Self-checking testbench of the counter compare outputs
`timescale 1ns/1ns
module fuc_compare_outputs_tb;
  logic clk_i;
  logic reset_n_i;
  logic [4:0] addr;
  logic rd_s;
  logic wr_s;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic wreq;
  logic [15:0] count_i;
  logic inc_i;
  logic dec_i;
  logic ext_rst_i;
  logic out1;
  logic out2;
  logic irq;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] d;
  // Kind (0 inc, 1 dec, 2 reset) and count after each event
  logic [17:0] sq [21] = '{
    {2'd1, 16'h0001}, {2'd1, 16'h0000}, {2'd1, 16'h9999},
    {2'd0, 16'h9999}, {2'd0, 16'h0000}, {2'd0, 16'h0001},
    {2'd1, 16'h0001}, {2'd1, 16'h0000}, {2'd0, 16'h0001},
    {2'd0, 16'h9998}, {2'd0, 16'h9999}, {2'd1, 16'h9998},
    {2'd0, 16'h0005}, {2'd2, 16'h0000}, {2'd1, 16'h9999},
    {2'd1, 16'h0004}, {2'd2, 16'h0000}, {2'd0, 16'h0001},
    {2'd0, 16'h0004}, {2'd0, 16'h0005}, {2'd1, 16'h0004}};
  logic [6:0] sq_carry = 7'b0111111;

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  fuc_compare_outputs u_fuc_compare_outputs (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .avs_address_i(addr),
    .avs_read_i(rd_s),
    .avs_write_i(wr_s),
    .avs_writedata_i(wdata),
    .avs_byteenable_i(be),
    .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq),
    .count_i(count_i),
    .inc_i(inc_i),
    .dec_i(dec_i),
    .ext_rst_i(ext_rst_i),
    .out1_o(out1),
    .out2_o(out2),
    .irq_o(irq)
  );

  fuc_proc_model u_fuc_proc_model (
    .clk_i(clk_i),
    .avs_waitrequest_i(wreq),
    .avs_readdata_i(rdata),
    .avs_address_o(addr),
    .avs_read_o(rd_s),
    .avs_write_o(wr_s),
    .avs_writedata_o(wdata),
    .avs_byteenable_o(be)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      mismatches++;
      finish_test();
    end
  end

  task automatic chk1(string n, logic e, logic g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic chk32(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic rdchk(string n, logic [4:0] a, logic [31:0] e);
    logic [31:0] v;
    u_fuc_proc_model.rd(a, v);
    chk32(n, e, v);
  endtask

  // One count event; count shows the value after it in the same cycle
  task automatic ev(input logic [1:0] k, input logic [15:0] v);
    @(posedge clk_i);
    inc_i <= (k == 2'd0);
    dec_i <= (k == 2'd1);
    ext_rst_i <= (k == 2'd2);
    count_i <= v;
    @(posedge clk_i);
    inc_i <= 1'b0;
    dec_i <= 1'b0;
    ext_rst_i <= 1'b0;
  endtask

  task automatic outs(logic e1, logic e2);
    repeat (3) @(posedge clk_i);
    chk1("out1", e1, out1);
    chk1("out2", e2, out2);
  endtask

  // Neutral start, flag scan to clear, then three events
  task automatic run_seq(int i);
    logic [31:0] v;
    ev(2'd0, 16'h0500);
    u_fuc_proc_model.scan(v);
    for (int j = 0; j < 3; j++)
      ev(sq[i*3+j][17:16], sq[i*3+j][15:0]);
    repeat (10) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdchk("ctrl", fuc_pkg::OFS_CTRL, 32'h00000000);
    rdchk("preset", fuc_pkg::OFS_PRESET, 32'h00000000);
    rdchk("flags", fuc_pkg::OFS_FLAGS, 32'h00000002);
    rdchk("status", fuc_pkg::OFS_IRQ_STATUS, 32'h00000000);
    rdchk("unmapped", 5'h1C, 32'h00000000);
    outs(1'b0, 1'b0);
    chk1("irq", 1'b0, irq);
  endtask

  task automatic t_manual();
    for (int i = 0; i < 4; i++)
    begin
      u_fuc_proc_model.set_ctrl(i[0], 1'b0, i[1], 1'b0);
      outs(i[0], i[1]);
    end
  endtask

  task automatic t_up();
    ev(2'd0, 16'h0100);
    u_fuc_proc_model.wr(fuc_pkg::OFS_PRESET, 32'h00000150);
    u_fuc_proc_model.set_ctrl(1'b0, 1'b1, 1'b1, 1'b1);
    outs(1'b0, 1'b1);
    ev(2'd0, 16'h0149);
    u_fuc_proc_model.scan(d);
    chk32("flags lt", 32'h4, d & 32'h7);
    ev(2'd0, 16'h0150);
    @(posedge clk_i);
    chk1("out1 fast", 1'b1, out1);
    chk1("out2 fast", 1'b0, out2);
    u_fuc_proc_model.scan(d);
    chk32("flags eq", 32'h2, d & 32'h7);
    rdchk("count", fuc_pkg::OFS_COUNT, 32'h00000150);
    rdchk("preset", fuc_pkg::OFS_PRESET, 32'h00000150);
    ev(2'd0, 16'h0151);
    u_fuc_proc_model.scan(d);
    chk32("flags gt", 32'h1, d & 32'h7);
    outs(1'b1, 1'b0);
    ev(2'd1, 16'h0149);
    outs(1'b0, 1'b1);
  endtask

  task automatic t_down();
    ev(2'd0, 16'h0200);
    u_fuc_proc_model.wr(fuc_pkg::OFS_PRESET, 32'h00000150);
    outs(1'b0, 1'b1);
    ev(2'd1, 16'h0150);
    @(posedge clk_i);
    chk1("out1 fast", 1'b1, out1);
    ev(2'd1, 16'h0149);
    outs(1'b1, 1'b0);
    ev(2'd0, 16'h0151);
    outs(1'b0, 1'b1);
    u_fuc_proc_model.wr(fuc_pkg::OFS_PRESET, 32'h00000151);
    outs(1'b1, 1'b0);
    ev(2'd1, 16'h0150);
    outs(1'b0, 1'b1);
  endtask

  task automatic t_carry();
    for (int i = 0; i < 7; i++)
    begin
      run_seq(i);
      u_fuc_proc_model.scan(d);
      chk1("carry", sq_carry[i], d[fuc_pkg::FLAG_CARRY]);
      u_fuc_proc_model.scan(d);
      chk1("carry reread", 1'b0, d[fuc_pkg::FLAG_CARRY]);
    end
  endtask

  task automatic t_irq();
    u_fuc_proc_model.wr(fuc_pkg::OFS_PRESET, 32'h00000510);
    u_fuc_proc_model.wr(fuc_pkg::OFS_IRQ_CLEAR, 32'h00000003);
    u_fuc_proc_model.wr(fuc_pkg::OFS_IRQ_ENABLE, 32'h00000000);
    run_seq(0);
    rdchk("status", fuc_pkg::OFS_IRQ_STATUS, 32'h00000001);
    chk1("irq masked", 1'b0, irq);
    u_fuc_proc_model.wr(fuc_pkg::OFS_IRQ_ENABLE, 32'h00000003);
    rdchk("enable", fuc_pkg::OFS_IRQ_ENABLE, 32'h00000003);
    chk1("irq set", 1'b1, irq);
    u_fuc_proc_model.wr(fuc_pkg::OFS_IRQ_CLEAR, 32'h00000001);
    rdchk("status", fuc_pkg::OFS_IRQ_STATUS, 32'h00000000);
    chk1("irq clear", 1'b0, irq);
    ev(2'd0, 16'h0510);
    rdchk("status eq", fuc_pkg::OFS_IRQ_STATUS, 32'h00000002);
    chk1("irq eq", 1'b1, irq);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset_n_i = 1'b0;
    count_i = 16'h0000;
    inc_i = 1'b0;
    dec_i = 1'b0;
    ext_rst_i = 1'b0;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_manual();
    t_up();
    t_down();
    t_carry();
    t_irq();
    finish_test();
  end
endmodule
